// ==== dofs_pkg.sv ====
package dofs_pkg;
   // FIFO geometry
   localparam int FIFO_DEPTH = 4096;
   localparam int PTR_W      = 12;
   localparam int CNT_W      = 13;
   localparam int SMP_W      = 16;
   localparam int SCNT_W     = 24;

   // Pacing limits and the fetch latency they must cover
   localparam int CLK_HZ         = 40000000;
   localparam int PACE_MAX_HZ    = 500000;
   localparam int PACE_MIN_CYC   = CLK_HZ / PACE_MAX_HZ;
   localparam int FETCH_MAX_CYC  = 3;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_COUNT  = 8'h0c;
   localparam logic [7:0] ADDR_DATA   = 8'h10;
   localparam logic [7:0] ADDR_SCOUNT = 8'h14;
   localparam logic [7:0] ADDR_DAC0   = 8'h18;
   localparam logic [7:0] ADDR_DAC1   = 8'h1c;

   // Control field positions
   localparam int CTRL_W        = 7;
   localparam int CTRL_WAVE     = 0;
   localparam int CTRL_TWO_DAC  = 1;
   localparam int CTRL_FIRST1   = 2;
   localparam int CTRL_CLK_EXT  = 3;
   localparam int CTRL_TSRC_LO  = 4;
   localparam int CTRL_TFALL    = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

   // Command bits
   localparam int CMD_ARM     = 0;
   localparam int CMD_ABRUPT  = 1;
   localparam int CMD_ORDERLY = 2;
   localparam int CMD_FRST    = 3;
   localparam int CMD_UFCLR   = 4;

   // Status bits
   localparam int STS_RUN   = 0;
   localparam int STS_UF    = 1;
   localparam int STS_EMPTY = 2;
   localparam int STS_FULL  = 3;
   localparam int STS_ARMED = 4;
   localparam int STS_STARV = 5;

   localparam logic [SCNT_W-1:0] SCOUNT_RST = 24'h000000;
   localparam logic [SMP_W-1:0]  DAC_RST    = 16'h8000;

   // Trigger sources
   typedef enum logic [1:0] {
      TRG_SW     = 2'b00,
      TRG_EXT    = 2'b01,
      TRG_THRESH = 2'b10
   } dofs_trg_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_RUN     = 2'b10,
      ST_ORDERLY = 2'b11
   } dofs_state_t;
endpackage : dofs_pkg

// ==== dofs_fifo_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dofs_fifo_if;
   import dofs_pkg::*;
   logic                 push;
   logic [SMP_W-1:0]     wdata;
   logic                 pop;
   logic [SMP_W-1:0]     rdata;
   logic                 retx;
   logic                 clr;
   logic [CNT_W-1:0]     count;
   logic                 empty;
   logic                 full;

   modport store (input push, wdata, pop, retx, clr, output rdata, count, empty, full);
   modport user  (output push, wdata, pop, retx, clr, input rdata, count, empty, full);
endinterface : dofs_fifo_if
`default_nettype wire

// ==== dofs_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module dofs_fifo (
   input wire logic       clk,
   input wire logic       rst,
   dofs_fifo_if.store     fp
);
   import dofs_pkg::*;

   logic [SMP_W-1:0] mem [FIFO_DEPTH];
   logic [CNT_W-1:0] wptr_q;
   logic [CNT_W-1:0] rptr_q;

   // Occupancy is the pointer distance
   assign fp.count = CNT_W'(wptr_q - rptr_q);
   assign fp.empty = (fp.count == '0);
   assign fp.full  = (fp.count == CNT_W'(FIFO_DEPTH));
   assign fp.rdata = mem[rptr_q[PTR_W-1:0]];

   // Sample storage, guarded against overfill
   always_ff @(posedge clk)
   begin
      if (fp.push && !fp.full)
         mem[wptr_q[PTR_W-1:0]] <= fp.wdata;
   end

   // Write pointer
   always_ff @(posedge clk)
   begin
      if (rst || fp.clr)
         wptr_q <= '0;
      else if (fp.push && !fp.full)
         wptr_q <= CNT_W'(wptr_q + 1'b1);
   end

   // Read pointer; retransmit rewinds to the pattern start
   always_ff @(posedge clk)
   begin
      if (rst || fp.clr)
         rptr_q <= '0;
      else if (fp.retx)
         rptr_q <= '0;
      else if (fp.pop && !fp.empty)
         rptr_q <= CNT_W'(rptr_q + 1'b1);
   end
endmodule : dofs_fifo
`default_nettype wire

// ==== dofs_seq_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dofs_seq_top (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output var  logic [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        pace_int_n,
   input  wire logic                        pace_ext,
   input  wire logic                        trig_ext,
   input  wire logic                        trig_thresh,
   output var  logic [dofs_pkg::SMP_W-1:0]  dac0_data,
   output var  logic [dofs_pkg::SMP_W-1:0]  dac1_data,
   output var  logic                        dac_load,
   output var  logic                        running
);
   import dofs_pkg::*;

   dofs_fifo_if fif ();

   dofs_fifo u_fifo (
      .clk (clk),
      .rst (rst),
      .fp  (fif)
   );

   logic [CTRL_W-1:0] ctrl_q;
   logic [SCNT_W-1:0] scount_q;
   logic [SCNT_W-1:0] done_q;
   dofs_state_t       state_q;
   logic              uf_q;
   logic              starv_q;
   logic              odd_pend_q;
   logic [SMP_W-1:0]  odd_q;
   logic [SMP_W-1:0]  hold_q;
   logic [1:0]        fetch_q;
   logic              pace_q;
   logic              trig_q;
   logic              retx_q;
   logic [STS_STARV:0] status;

   // Register decode shared by reads and writes
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_STATUS) || (a == ADDR_COUNT)
               || (a == ADDR_DATA) || (a == ADDR_SCOUNT) || (a == ADDR_DAC0) || (a == ADDR_DAC1);
   endfunction : is_mapped

   logic              acc;
   logic              data_wr;
   logic              wr_fire;
   logic              cmd_wr;
   logic [4:0]        cmd;
   logic              active;
   logic              two_dac;
   logic              wave;
   logic              first1;
   logic              pace_lvl;
   logic              pace_fall;
   logic              trig_lvl;
   logic              trig_hit;
   logic              fetch_go;
   logic              pace_empty;
   logic [1:0]        need;
   dofs_trg_t         tsrc;

   // Bus qualifiers
   assign acc     = psel && penable;
   assign data_wr = acc && pwrite && (paddr == ADDR_DATA);
   // Data word waits while the odd half is pending or two slots are not free
   assign pready  = !(data_wr && (odd_pend_q || (fif.count > CNT_W'(FIFO_DEPTH - 2))));
   assign pslverr = acc && !is_mapped(paddr);
   assign wr_fire = acc && pwrite && pready && is_mapped(paddr);
   assign cmd_wr  = wr_fire && (paddr == ADDR_CMD);
   assign cmd     = cmd_wr ? pwdata[4:0] : 5'h00;

   // Control field views
   assign wave    = ctrl_q[CTRL_WAVE];
   assign two_dac = ctrl_q[CTRL_TWO_DAC];
   assign first1  = ctrl_q[CTRL_FIRST1];
   assign tsrc    = dofs_trg_t'(ctrl_q[CTRL_TSRC_LO +: 2]);
   assign active  = (state_q == ST_RUN) || (state_q == ST_ORDERLY);
   assign running = active;
   assign need    = two_dac ? 2'd2 : 2'd1;

   // Pacing clock select and falling edge
   assign pace_lvl  = ctrl_q[CTRL_CLK_EXT] ? pace_ext : pace_int_n;
   assign pace_fall = pace_q && !pace_lvl;

   // Trigger select and edge of the configured polarity
   assign trig_lvl = (tsrc == TRG_THRESH) ? trig_thresh : trig_ext;
   always_comb
   begin
      case (tsrc)
         TRG_SW:     trig_hit = 1'b1;
         TRG_EXT,
         TRG_THRESH: trig_hit = ctrl_q[CTRL_TFALL] ? (trig_q && !trig_lvl)
                                                   : (!trig_q && trig_lvl);
         default:    trig_hit = 1'b0;
      endcase
   end

   // A pacing edge either starts a fetch or finds too little data
   assign fetch_go   = active && pace_fall && (fetch_q == 2'd0)
                    && (fif.count >= CNT_W'(need)) && !retx_q;
   assign pace_empty = active && pace_fall && !fetch_go && !wave;

   // FIFO drive: even half on the bus edge, odd half one cycle later
   assign fif.push  = (wr_fire && (paddr == ADDR_DATA)) || odd_pend_q;
   assign fif.wdata = odd_pend_q ? odd_q : pwdata[SMP_W-1:0];
   assign fif.pop   = (fetch_q != 2'd0);
   assign fif.clr   = cmd[CMD_FRST];
   assign fif.retx  = retx_q;

   // Edge detector history
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pace_q <= 1'b1;
         trig_q <= 1'b0;
      end
      else
      begin
         pace_q <= pace_lvl;
         trig_q <= trig_lvl;
      end
   end

   // Pending odd sample of a data word
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         odd_pend_q <= 1'b0;
         odd_q      <= '0;
      end
      else if (wr_fire && (paddr == ADDR_DATA))
      begin
         odd_pend_q <= 1'b1;
         odd_q      <= pwdata[31:16];
      end
      else
         odd_pend_q <= 1'b0;
   end

   // Writable configuration
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_q   <= CTRL_RST;
         scount_q <= SCOUNT_RST;
      end
      else if (wr_fire && (paddr == ADDR_CTRL))
         ctrl_q <= pwdata[CTRL_W-1:0];
      else if (wr_fire && (paddr == ADDR_SCOUNT))
         scount_q <= pwdata[SCNT_W-1:0];
   end

   // Sequencer: arm, trigger, run, orderly or abrupt stop
   always_ff @(posedge clk)
   begin
      if (rst)
         state_q <= ST_IDLE;
      else if (cmd[CMD_ABRUPT])
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:    if (cmd[CMD_ARM]) state_q <= ST_ARMED;
            ST_ARMED:   if (trig_hit) state_q <= ST_RUN;
            ST_RUN:     if (cmd[CMD_ORDERLY]) state_q <= ST_ORDERLY;
            ST_ORDERLY: if ((fetch_q == 2'd0) && !fetch_go && (done_q >= scount_q))
                           state_q <= ST_IDLE;
            default:    state_q <= ST_IDLE;
         endcase
      end
   end

   // Samples fetched since arming, for the orderly stop
   always_ff @(posedge clk)
   begin
      if (rst || (cmd[CMD_ARM] && (state_q == ST_IDLE)))
         done_q <= '0;
      else if (fif.pop)
         done_q <= SCNT_W'(done_q + 1'b1);
   end

   // Fetch sequence: one or two pops per pacing edge
   always_ff @(posedge clk)
   begin
      if (rst || cmd[CMD_ABRUPT] || cmd[CMD_FRST])
         fetch_q <= 2'd0;
      else if (fetch_go)
         fetch_q <= need;
      else if (fetch_q != 2'd0)
         fetch_q <= fetch_q - 2'd1;
   end

   // Retransmit pulse when a waveform run drains the FIFO
   always_ff @(posedge clk)
   begin
      if (rst)
         retx_q <= 1'b0;
      else
         retx_q <= active && wave && fif.empty && (fetch_q == 2'd0) && !retx_q && !fetch_go;
   end

   // DAC latches: both list entries change on the same edge
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hold_q    <= '0;
         dac0_data <= DAC_RST;
         dac1_data <= DAC_RST;
         dac_load  <= 1'b0;
      end
      else
      begin
         dac_load <= 1'b0;
         if (fetch_q == 2'd2)
            hold_q <= fif.rdata;
         else if ((fetch_q == 2'd1) && two_dac)
         begin
            dac_load <= 1'b1;
            if (first1)
            begin
               dac1_data <= hold_q;
               dac0_data <= fif.rdata;
            end
            else
            begin
               dac0_data <= hold_q;
               dac1_data <= fif.rdata;
            end
         end
         else if (fetch_q == 2'd1)
         begin
            dac_load <= 1'b1;
            if (first1)
               dac1_data <= fif.rdata;
            else
               dac0_data <= fif.rdata;
         end
      end
   end

   // Starved pacing edge: hold the last value, no error yet
   always_ff @(posedge clk)
   begin
      if (rst || cmd[CMD_FRST])
         starv_q <= 1'b0;
      else if (pace_empty)
         starv_q <= 1'b1;
      else if (fif.push)
         starv_q <= 1'b0;
   end

   // Underflow flag: a late write after starvation sets it, set beats clear
   always_ff @(posedge clk)
   begin
      if (rst)
         uf_q <= 1'b0;
      else if (starv_q && fif.push)
         uf_q <= 1'b1;
      else if (cmd[CMD_UFCLR])
         uf_q <= 1'b0;
   end

   // Status word assembled at its named bit positions
   always_comb
   begin
      status            = '0;
      status[STS_RUN]   = active;
      status[STS_UF]    = uf_q;
      status[STS_EMPTY] = fif.empty;
      status[STS_FULL]  = fif.full;
      status[STS_ARMED] = (state_q == ST_ARMED);
      status[STS_STARV] = starv_q;
   end

   // Read data registered in the setup phase
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            ADDR_CTRL:   prdata <= 32'(ctrl_q);
            ADDR_STATUS: prdata <= 32'(status);
            ADDR_COUNT:  prdata <= 32'(fif.count);
            ADDR_SCOUNT: prdata <= 32'(scount_q);
            ADDR_DAC0:   prdata <= 32'(dac0_data);
            ADDR_DAC1:   prdata <= 32'(dac1_data);
            default:     prdata <= 32'h00000000;
         endcase
      end
   end
endmodule : dofs_seq_top
`default_nettype wire

// ==== dofs_pace_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dofs_pace_model #(
   parameter int PERIOD = 40
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic en,
   output var  logic pace_int_n
);
   logic [7:0] cnt_q;

   // Active-low pacing pulse, one falling edge per period, idle high when off
   always_ff @(posedge clk)
   begin
      if (rst || !en)
      begin
         cnt_q      <= 8'h00;
         pace_int_n <= 1'b1;
      end
      else
      begin
         cnt_q      <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
         pace_int_n <= (cnt_q < 8'(PERIOD / 2));
      end
   end
endmodule : dofs_pace_model
`default_nettype wire

// ==== dofs_seq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dofs_seq_assertions (
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [7:0]                 paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [dofs_pkg::SMP_W-1:0] dac0_data,
   input wire logic [dofs_pkg::SMP_W-1:0] dac1_data,
   input wire logic                       dac_load,
   input wire logic                       running
);
   import dofs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Bus access phase, abrupt stop taken, sequencer idle for a while
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_abrupt;
      s_access ##0 (pready && pwrite && paddr == ADDR_CMD && pwdata[CMD_ABRUPT]);
   endsequence
   sequence s_idle4;
      !running [*4];
   endsequence

   a_reset_vals: assert property ($fell(rst) |-> dac0_data == DAC_RST && dac1_data == DAC_RST && !running)
      else $error("outputs not at reset values");
   a_codes_hold: assert property (!dac_load && !$past(rst) |-> $stable(dac0_data) && $stable(dac1_data))
      else $error("dac codes changed without a load");
   a_load_pulse: assert property (dac_load |=> !dac_load)
      else $error("dac load longer than one cycle");
   a_stall_cause: assert property (!pready |-> psel && penable && pwrite && paddr == ADDR_DATA)
      else $error("wait state outside a data write");
   a_stall_bound: assert property (s_access ##0 !pready |-> ##[1:1000] pready)
      else $error("data write stalled too long");
   a_unmapped_err: assert property (s_access ##0 paddr[7:5] != 3'b000 |-> pslverr)
      else $error("unmapped access not refused");
   a_read_zero: assert property (s_access ##0 (!pwrite && (paddr == ADDR_CMD || paddr == ADDR_DATA
      || paddr[7:5] != 3'b000)) |-> prdata == 32'h0)
      else $error("write-only or unmapped read not zero");
   a_abrupt_halt: assert property (s_abrupt |=> !running)
      else $error("abrupt stop did not halt");
   a_idle_quiet: assert property (s_idle4 |-> !dac_load)
      else $error("dac load while idle");
endmodule : dofs_seq_assertions

bind dofs_seq_top dofs_seq_assertions chk_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .dac0_data, .dac1_data, .dac_load, .running);
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dofs_pkg::*;
   logic             clk, rst, psel, penable, pwrite, pace_en, trig_ext, pace_int_n;
   logic             pace_ext, trig_thresh, q_err;
   logic             pready, pslverr, dac_load, running;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, q;
   logic [SMP_W-1:0] dac0_data, dac1_data;
   int               n_errors, num_checks;
   int               cyc = 0;

   dofs_seq_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .pace_int_n, .pace_ext, .trig_ext, .trig_thresh, .dac0_data, .dac1_data, .dac_load, .running);
   dofs_pace_model #(.PERIOD(40)) pace_u (.clk, .rst, .en(pace_en), .pace_int_n);

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // One APB transfer, held until pready; read data lands in q
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      q_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd

   // Wait for the next dac load pulse
   task automatic wl;
      do @(negedge clk); while (dac_load !== 1'b1);
   endtask : wl

   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         test_done;
      end
   end

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pace_en = 1'b0;
      trig_ext = 1'b0;
      pace_ext = 1'b1;
      trig_thresh = 1'b0;
      n_errors = 0;
      num_checks = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // Reset state and a refused address
      rd(ADDR_COUNT, 32'h0);
      rd(ADDR_STATUS, 32'h4);
      rd(ADDR_DAC0, 32'h8000);
      rd(8'h40, 32'h0);
      chk({31'h0, q_err}, 32'h1);
      // Two DACs, continuous, then starving and underflow
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_DATA, 32'h2222_1111);
      apb(1'b1, ADDR_DATA, 32'h4444_3333);
      rd(ADDR_COUNT, 32'h4);
      apb(1'b1, ADDR_CMD, 32'h1);
      pace_en <= 1'b1;
      wl;
      chk({dac1_data, dac0_data}, 32'h2222_1111);
      wl;
      chk({dac1_data, dac0_data}, 32'h4444_3333);
      repeat (100) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h23, 32'h21);
      chk({dac1_data, dac0_data}, 32'h4444_3333);
      apb(1'b1, ADDR_DATA, 32'h6666_5555);
      wl;
      chk({dac1_data, dac0_data}, 32'h6666_5555);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h3, 32'h3);
      apb(1'b1, ADDR_CMD, 32'h10);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h2, 32'h0);
      apb(1'b1, ADDR_CMD, 32'h2);
      @(negedge clk);
      chk({31'h0, running}, 32'h0);
      // Waveform, one DAC starting at DAC1, rising external trigger
      apb(1'b1, ADDR_CMD, 32'h8);
      rd(ADDR_COUNT, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h15);
      apb(1'b1, ADDR_DATA, 32'hbbbb_aaaa);
      apb(1'b1, ADDR_DATA, 32'hdddd_cccc);
      apb(1'b1, ADDR_CMD, 32'h1);
      trig_ext <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         wl;
         chk({16'h0, dac1_data}, {16'h0, 16'(32'haaaa + (i % 4) * 32'h1111)});
      end
      apb(1'b1, ADDR_CMD, 32'h2);
      trig_ext <= 1'b0;
      repeat (3) @(posedge clk);
      trig_ext <= 1'b1;
      repeat (3) @(negedge clk);
      chk({31'h0, running}, 32'h0);
      // Two DACs from DAC1, external pace, falling threshold trigger
      pace_en <= 1'b0;
      apb(1'b1, ADDR_CMD, 32'h8);
      apb(1'b1, ADDR_CTRL, 32'h6e);
      apb(1'b1, ADDR_DATA, 32'h8888_7777);
      apb(1'b1, ADDR_CMD, 32'h1);
      trig_thresh <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h11, 32'h10);
      trig_thresh <= 1'b0;
      repeat (3) @(posedge clk);
      pace_ext <= 1'b0;
      wl;
      chk({dac1_data, dac0_data}, 32'h7777_8888);
      apb(1'b1, ADDR_CMD, 32'h2);
      pace_ext <= 1'b1;
      // Fill to capacity, then orderly stop with one write stalled
      apb(1'b1, ADDR_CMD, 32'h8);
      apb(1'b1, ADDR_CTRL, 32'h0);
      for (int i = 0; i < 2048; i++)
         apb(1'b1, ADDR_DATA, {16'(2 * i + 1), 16'(2 * i)});
      rd(ADDR_COUNT, 32'h1000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'h8, 32'h8);
      apb(1'b1, ADDR_SCOUNT, 32'h3);
      apb(1'b1, ADDR_CMD, 32'h1);
      apb(1'b1, ADDR_CMD, 32'h4);
      pace_en <= 1'b1;
      apb(1'b1, ADDR_DATA, 32'hffff_fffe);
      while (running !== 1'b0) @(negedge clk);
      chk({16'h0, dac0_data}, 32'h2);
      rd(ADDR_COUNT, 32'hfff);
      test_done;
   end
endmodule : tb
`default_nettype wire
